// ==== aic_host.sv ====
// host end: software port drives conversions in poll or interrupt mode
module aic_host #(
  parameter int TIMEOUT_CYCLES = aic_pkg::SAMPLE_MAX_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  aic_if.host bus,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata
);
  aic_pkg::aic_host_state_type state_reg;
  logic [3:0] chan_reg;
  logic poll_reg;
  logic done_reg;
  logic tout_reg;
  logic [11:0] res_reg;
  logic [15:0] wait_reg;
  logic pending_reg;
  logic go;
  logic [15:0] sw_rd_mux;
  logic late;
  assign go = sw_wr && (sw_addr == aic_pkg::HREG_CTRL) && sw_wdata[aic_pkg::CTRL_GO_POS];
  assign late = wait_reg >= 16'(TIMEOUT_CYCLES);
  assign sw_rd_mux = (sw_addr == aic_pkg::HREG_STATUS) ?
                     {13'h0000, tout_reg, done_reg, state_reg != aic_pkg::AIC_H_IDLE} :
                     (sw_addr == aic_pkg::HREG_RESULT) ? {4'h0, res_reg} : 16'h0000;
  // conversion sequence: command, wait, read low then high byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= aic_pkg::AIC_H_IDLE;
      chan_reg <= 4'h0;
      poll_reg <= 1'b0;
      done_reg <= 1'b0;
      tout_reg <= 1'b0;
      res_reg <= 12'h000;
      wait_reg <= 16'h0000;
      pending_reg <= 1'b0;
      bus.port_addr <= 2'h0;
      bus.wr_data <= 8'h00;
      bus.wr_strobe <= 1'b0;
      bus.rd_strobe <= 1'b0;
      sw_rdata <= 16'h0000;
    end else begin
      sw_rdata <= sw_rd ? sw_rd_mux : 16'h0000;
      bus.wr_strobe <= 1'b0;
      bus.rd_strobe <= 1'b0;
      pending_reg <= bus.rd_strobe;
      wait_reg <= (state_reg == aic_pkg::AIC_H_IDLE) ? 16'h0000 : wait_reg + 16'h0001;
      case (state_reg)
        aic_pkg::AIC_H_IDLE: begin
          if (go) begin
            chan_reg <= sw_wdata[3:0];
            poll_reg <= sw_wdata[aic_pkg::CTRL_POLL_POS];
            done_reg <= 1'b0;
            tout_reg <= 1'b0;
            bus.port_addr <= aic_pkg::PORT_CMD;
            bus.wr_data <= {4'h0, sw_wdata[3:0]};
            bus.wr_strobe <= 1'b1;
            state_reg <= aic_pkg::AIC_H_WAIT;
          end
        end
        aic_pkg::AIC_H_WAIT: begin
          if (late) begin
            tout_reg <= 1'b1;
            state_reg <= aic_pkg::AIC_H_IDLE;
          end else if (poll_reg && !bus.rd_strobe && !pending_reg) begin
            bus.port_addr <= aic_pkg::PORT_LOW_KEEP;
            bus.rd_strobe <= 1'b1;
            state_reg <= aic_pkg::AIC_H_POLL;
          end else if (!poll_reg && !bus.intr_n) begin
            bus.port_addr <= aic_pkg::PORT_LOW_CLR;
            bus.rd_strobe <= 1'b1;
            state_reg <= aic_pkg::AIC_H_RDLO;
          end
        end
        aic_pkg::AIC_H_POLL: begin
          if (pending_reg) begin
            if (bus.rd_data[aic_pkg::LOW_EOC_POS]) begin
              res_reg[3:0] <= bus.rd_data[7:aic_pkg::LOW_DATA_POS];
              bus.port_addr <= aic_pkg::PORT_HIGH_CLR;
              bus.rd_strobe <= 1'b1;
              state_reg <= aic_pkg::AIC_H_RDHI;
            end else begin
              state_reg <= aic_pkg::AIC_H_WAIT;
            end
          end
        end
        aic_pkg::AIC_H_RDLO: begin
          if (pending_reg) begin
            res_reg[3:0] <= bus.rd_data[7:aic_pkg::LOW_DATA_POS];
            bus.port_addr <= aic_pkg::PORT_HIGH_KEEP;
            bus.rd_strobe <= 1'b1;
            state_reg <= aic_pkg::AIC_H_RDHI;
          end
        end
        aic_pkg::AIC_H_RDHI: begin
          if (pending_reg) begin
            res_reg[11:4] <= bus.rd_data;
            state_reg <= aic_pkg::AIC_H_END;
          end
        end
        aic_pkg::AIC_H_END: begin
          done_reg <= 1'b1;
          state_reg <= aic_pkg::AIC_H_IDLE;
        end
        default: state_reg <= aic_pkg::AIC_H_IDLE;
      endcase
    end
  end
endmodule // aic_host

// ==== aic_pkg.sv ====
// package of constants for the analog input conversion control ends
// How it works
// - host reaches module only by port reads/writes
// - conversion starts only on host start command
// - status shows end-of-conversion flag for polling
// - active-low interrupt asserts when conversion completes
// - interrupt capability always present, not optional
// - result read as low byte then high byte
// - conversion takes nominal 35 microseconds
// - whole sample takes at most 54 microseconds
// - bipolar range gives sign plus 11 magnitude bits
// - mode picks 8 differential or 16 single-ended
// - any channel per conversion, no fixed scan
// - one write picks channel and starts conversion
// - low byte: data 3..0, start, eoc, irq
// - high byte holds result bits 11 to 4
// - port choice decides whether read clears irq
package aic_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_US = 35;
  localparam int SAMPLE_MAX_US = 54;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int SAMPLE_MAX_CYCLES = SAMPLE_MAX_US * CLK_MHZ;
  localparam logic [1:0] PORT_CMD = 2'h0; // write: channel and start
  localparam logic [1:0] PORT_LOW_CLR = 2'h0; // low byte, clears irq
  localparam logic [1:0] PORT_HIGH_CLR = 2'h1; // high byte, clears irq
  localparam logic [1:0] PORT_LOW_KEEP = 2'h2; // low byte, irq kept
  localparam logic [1:0] PORT_HIGH_KEEP = 2'h3; // high byte, irq kept
  localparam int LOW_DATA_POS = 4;
  localparam int LOW_START_POS = 2;
  localparam int LOW_EOC_POS = 1;
  localparam int LOW_IRQ_POS = 0;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  // host controller register offsets (software side)
  localparam logic [3:0] HREG_CTRL = 4'h0; // w: [3:0] channel, [8] go, [9] poll mode
  localparam logic [3:0] HREG_STATUS = 4'h1; // r: [0] busy, [1] done, [2] timeout
  localparam logic [3:0] HREG_RESULT = 4'h2; // r: [11:0] result
  localparam int CTRL_GO_POS = 8;
  localparam int CTRL_POLL_POS = 9;
  typedef enum logic [1:0] {
    AIC_D_IDLE = 2'b00,
    AIC_D_CONV = 2'b01,
    AIC_D_DONE = 2'b10
  } aic_dev_state_type;
  typedef enum logic [2:0] {
    AIC_H_IDLE = 3'b000,
    AIC_H_WAIT = 3'b001,
    AIC_H_POLL = 3'b010,
    AIC_H_RDLO = 3'b011,
    AIC_H_RDHI = 3'b100,
    AIC_H_END = 3'b101
  } aic_host_state_type;
  // places a 12-bit value in the low or high read byte
  function automatic logic [7:0] aic_byte(input logic [11:0] res, input logic hi,
                                          input logic st, input logic eoc, input logic irq_n);
    aic_byte = hi ? res[11:4] : {res[3:0], 1'b0, st, eoc, irq_n};
  endfunction
endpackage

// ==== aic_if.sv ====
// port-level connection between host and analog input module
interface aic_if;
  logic [1:0] port_addr;
  logic [7:0] wr_data;
  logic wr_strobe;
  logic rd_strobe;
  logic [7:0] rd_data;
  logic intr_n;
  modport dev (input port_addr, input wr_data, input wr_strobe, input rd_strobe,
               output rd_data, output intr_n);
  modport host (output port_addr, output wr_data, output wr_strobe, output rd_strobe,
                input rd_data, input intr_n);
endinterface

// ==== aic_sar.sv ====
// successive approximation engine: one bit per step against a sample
module aic_sar #(
  parameter int STEP_CYCLES = aic_pkg::CONV_CYCLES / 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [11:0] sample,
  output logic done,
  output logic [11:0] result
);
  logic [11:0] trial_reg;
  logic [11:0] bit_reg;
  logic [15:0] cnt_reg;
  logic busy_reg;
  logic step;
  logic [11:0] cand;
  assign step = busy_reg && (cnt_reg == 16'(STEP_CYCLES - 1));
  assign cand = trial_reg | bit_reg;
  // one comparison per step, msb first
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trial_reg <= 12'h000;
      bit_reg <= 12'h000;
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done <= 1'b0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start) begin
        trial_reg <= 12'h000;
        bit_reg <= 12'h800;
        cnt_reg <= 16'h0000;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= step ? 16'h0000 : cnt_reg + 16'h0001;
        if (step) begin
          if (cand <= sample) trial_reg <= cand;
          bit_reg <= bit_reg >> 1;
          if (bit_reg == 12'h001) begin
            busy_reg <= 1'b0;
            done <= 1'b1;
            result <= (cand <= sample) ? cand : trial_reg;
          end
        end
      end
    end
  end
endmodule // aic_sar

// ==== aic_dev.sv ====
// module end: port decode, channel mux, conversion and status bytes
module aic_dev #(
  parameter int STEP_CYCLES = aic_pkg::CONV_CYCLES / 12
) (
  input wire logic clk,
  input wire logic reset_n,
  aic_if.dev bus,
  input wire logic diff_mode,
  input wire logic bipolar,
  input wire logic [191:0] analog_in,
  output logic busy,
  output logic [3:0] channel
);
  aic_pkg::aic_dev_state_type state_reg;
  logic [3:0] chan_reg;
  logic [11:0] res_reg;
  logic eoc_reg;
  logic irq_n_reg;
  logic start_reg;
  logic sar_done;
  logic [11:0] sar_res;
  logic cmd_wr;
  logic clr_rd;
  logic [3:0] eff_chan;
  logic [11:0] sample;
  logic [11:0] fmt_res;
  logic rd_hi;
  logic conv_fin;
  assign cmd_wr = bus.wr_strobe && (bus.port_addr == aic_pkg::PORT_CMD);
  assign clr_rd = bus.rd_strobe && !bus.port_addr[1];
  assign rd_hi = bus.port_addr[0];
  // a done pulse left over from an aborted conversion must not finish the restarted one
  assign conv_fin = sar_done && (state_reg == aic_pkg::AIC_D_CONV) && !start_reg;
  assign eff_chan = diff_mode ? {1'b0, bus.wr_data[2:0]} : bus.wr_data[3:0];
  assign sample = analog_in[chan_reg*12 +: 12];
  assign fmt_res = bipolar ? {~sar_res[11], sar_res[10:0]} : sar_res;
  aic_sar #(.STEP_CYCLES(STEP_CYCLES)) u_sar (
    .clk(clk),
    .reset_n(reset_n),
    .start(start_reg),
    .sample(sample),
    .done(sar_done),
    .result(sar_res)
  );
  // command, completion and read handling; completion beats a clearing read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= aic_pkg::AIC_D_IDLE;
      chan_reg <= 4'h0;
      res_reg <= aic_pkg::RESULT_RESET;
      eoc_reg <= 1'b0;
      irq_n_reg <= 1'b1;
      start_reg <= 1'b0;
      bus.rd_data <= 8'h00;
      bus.intr_n <= 1'b1;
      busy <= 1'b0;
      channel <= 4'h0;
    end else begin
      start_reg <= cmd_wr;
      if (cmd_wr) begin
        chan_reg <= eff_chan;
        eoc_reg <= 1'b0;
        state_reg <= aic_pkg::AIC_D_CONV;
      end else if (conv_fin) begin
        res_reg <= fmt_res;
        eoc_reg <= 1'b1;
        state_reg <= aic_pkg::AIC_D_DONE;
      end
      if (conv_fin && !cmd_wr) irq_n_reg <= 1'b0;
      else if (clr_rd || cmd_wr) irq_n_reg <= 1'b1;
      if (bus.rd_strobe) begin
        bus.rd_data <= aic_pkg::aic_byte(res_reg, rd_hi, state_reg == aic_pkg::AIC_D_CONV,
                                         eoc_reg, irq_n_reg);
      end else begin
        bus.rd_data <= 8'h00;
      end
      bus.intr_n <= (conv_fin && !cmd_wr) ? 1'b0 :
                    ((clr_rd || cmd_wr) ? 1'b1 : irq_n_reg);
      busy <= cmd_wr || (state_reg == aic_pkg::AIC_D_CONV && !conv_fin);
      channel <= cmd_wr ? eff_chan : chan_reg;
    end
  end
endmodule // aic_dev

// ==== aic_monitor.sv ====
// assertions on the port-level connection between host end and module end
module aic_monitor #(
  parameter int STEP_CYCLES = aic_pkg::CONV_CYCLES / 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] port_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_data,
  input wire logic intr_n
);
  localparam int CONV_LO = 12 * STEP_CYCLES;
  logic [15:0] since_cmd_reg;
  // decoded bus events
  wire cmd_w = wr_strobe && port_addr == aic_pkg::PORT_CMD;
  wire low_rd_w = rd_strobe && !port_addr[0];
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles since the last start command, saturating so no stale command counts
  always_ff @(posedge clk) begin
    if (!reset_n) since_cmd_reg <= 16'hFFFF;
    else if (cmd_w) since_cmd_reg <= 16'h0000;
    else if (since_cmd_reg != 16'hFFFF) since_cmd_reg <= since_cmd_reg + 16'h0001;
  end
  a_rd_idle_zero: assert property (!rd_strobe |=> rd_data == 8'h00)
    else $error("read data not zero outside a read answer");
  a_irq_on_done: assert property ($fell(intr_n) |->
    since_cmd_reg >= CONV_LO && since_cmd_reg <= CONV_LO + 8)
    else $error("interrupt request not at conversion end");
  a_cmd_clears_irq: assert property (cmd_w |=> intr_n [*8])
    else $error("interrupt request low soon after a command");
  a_clr_read_irq: assert property (rd_strobe && !port_addr[1] && !intr_n |=> intr_n)
    else $error("clearing read left interrupt request low");
  a_keep_read_irq: assert property (rd_strobe && port_addr[1] && !intr_n |=> !intr_n)
    else $error("keeping read released interrupt request");
  a_eoc_at_done: assert property (low_rd_w && !intr_n |=> rd_data[aic_pkg::LOW_EOC_POS])
    else $error("end of conversion missing while request pending");
  a_eoc_cleared: assert property (low_rd_w && since_cmd_reg < CONV_LO |=>
    !rd_data[aic_pkg::LOW_EOC_POS])
    else $error("end of conversion shown before result ready");
  a_irq_bit_shown: assert property (rd_strobe && port_addr == aic_pkg::PORT_LOW_KEEP |=>
    rd_data[aic_pkg::LOW_IRQ_POS] == $past(intr_n))
    else $error("low byte request bit differs from request line");
  a_low_gap_zero: assert property (low_rd_w |=> !rd_data[3])
    else $error("unused low byte bit set");
  // main scenarios reached
  c_irq_fall: cover property ($fell(intr_n));
  c_keep_pending: cover property (rd_strobe && port_addr == aic_pkg::PORT_LOW_KEEP && !intr_n);
  c_high_clear: cover property (rd_strobe && port_addr == aic_pkg::PORT_HIGH_CLR);
endmodule // aic_monitor

// ==== test_analog_input_conversion_control.sv ====
// self-checking bench: host end drives module end across the interface
module test_analog_input_conversion_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic diff_mode = 1'b0;
  logic bipolar = 1'b0;
  logic [191:0] analog_in = '0;
  logic busy;
  logic [3:0] channel;
  logic rd_seen = 1'b0;
  logic [16:0] exp_q[$];
  logic [16:0] note;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  aic_if bus_w();
  aic_dev #(.STEP_CYCLES(2)) aic_dev_i (.clk(clk), .reset_n(reset_n), .bus(bus_w),
    .diff_mode(diff_mode), .bipolar(bipolar), .analog_in(analog_in), .busy(busy),
    .channel(channel));
  aic_host #(.TIMEOUT_CYCLES(60)) aic_host_i (.clk(clk), .reset_n(reset_n), .bus(bus_w),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  aic_monitor #(.STEP_CYCLES(2)) aic_monitor_i (.clk(clk), .reset_n(reset_n),
    .port_addr(bus_w.port_addr), .wr_data(bus_w.wr_data), .wr_strobe(bus_w.wr_strobe),
    .rd_strobe(bus_w.rd_strobe), .rd_data(bus_w.rd_data), .intr_n(bus_w.intr_n));
  // 100 MHz clock
  always #5 clk = ~clk;
  // compare one value and count it
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  // counts, verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one software write strobe
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask
  // one software read; note bit 16 says whether the answer is compared
  task automatic sw_read(input logic [3:0] a, input logic [16:0] e, output logic [15:0] d);
    exp_q.push_back(e);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(posedge clk);
    d = sw_rdata;
  endtask
  // answer watcher: takes the oldest note when read data stand
  always @(posedge clk) begin
    rd_seen <= sw_rd;
    if (rd_seen && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[16]) check("sw_rdata", sw_rdata, note[15:0]);
    end
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  // conversions on random channels in poll and interrupt mode
  initial begin
    logic [15:0] d;
    logic [3:0] ch;
    logic [11:0] s;
    void'($urandom(32'h7EA2));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      analog_in <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      ch = 4'($urandom);
      bipolar <= (i == 4);
      diff_mode <= (i == 5);
      @(posedge clk);
      s = analog_in[12 * ((i == 5) ? {1'b0, ch[2:0]} : ch) +: 12] ^ ((i == 4) ? 12'h800 : 12'h000);
      sw_write(aic_pkg::HREG_CTRL, {6'h00, i[0], 1'b1, 4'h0, ch});
      sw_write(aic_pkg::HREG_CTRL, {8'h01, 4'h0, ~ch});
      check("busy", {15'h0000, busy}, 16'h0001);
      d = 16'h0001;
      for (int k = 0; k < 100 && d[0] === 1'b1; k++) begin
        sw_read(aic_pkg::HREG_STATUS, 17'h00000, d);
      end
      sw_read(aic_pkg::HREG_STATUS, 17'h10002, d);
      sw_read(aic_pkg::HREG_RESULT, {1'b1, 4'h0, s}, d);
      check("channel", {12'h000, channel}, (i == 5) ? {13'h0000, ch[2:0]} : {12'h000, ch});
      check("intr_n", {15'h0000, bus_w.intr_n}, 16'h0001);
      check("busy idle", {15'h0000, busy}, 16'h0000);
      $display("test %0d done", i);
    end
    sw_read(4'hF, 17'h10000, d);
    @(posedge clk);
    results();
  end
endmodule // test_analog_input_conversion_control
